// >>> design/otscs_top.sv
`timescale 1ns/100ps
`include "otscs_cfg.svh"

// Behaviour
// - The reference trim is a 7-bit two's-complement load-capacitance code of 128 values.
// - The most negative reference code gives the lowest frequency, the most positive the highest.
// - The reference trim reads zero after reset release and throughout cold boot.
// - Once the reference oscillator is stable the trim takes its default code, then software may change it.
// - The reference oscillator stops in low-power modes and its trim is kept across Sleep and Backup.
// - Waking from Deep Sleep restarts the reference trim at zero and reloads the default when stable.
// - The sleep clock source is one of three and the choice is taken only once per start-up.
// - After start-up the sleep clock runs from the internal slow oscillator until another is chosen.
// - The sleep trim is a 5-bit two's-complement load-capacitance code of 32 values.
// - The most positive sleep code gives the lowest frequency, the most negative the highest.
// - The sleep trim reads zero after reset or cold boot and takes its default once stable.
// - The sleep clock oscillation stops in Deep Sleep.
// - Waking from Deep Sleep restarts the sleep trim at zero and reloads the default when stable.
module otscs_top
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire otscs_pkg::otscs_mode_t pmu_mode,
    input wire logic ref_osc_ready,
    input wire logic slow_osc_ready,
    output logic ref_osc_en,
    output logic slow_osc_en,
    output otscs_pkg::otscs_trim_t osc_trim
);
    import otscs_pkg::*;

    function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] off);
        reg_hit = (addr[31:8] == 24'h0) && (addr[7:2] == off[7:2]);
    endfunction

    logic [1:0] rdy_s1_q;
    logic [1:0] rdy_s2_q;
    logic [1:0] rdy_s3_q;
    logic [1:0] rdy_f_q;
    logic [1:0] rdy_raw;
    logic ref_rdy;
    logic slow_rdy;

    logic addr_ok;
    logic rd_req;
    logic wr_req;
    logic wr_pend_q;
    logic [31:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_val;

    otscs_init_t ref_st_q;
    otscs_init_t slow_st_q;
    logic [`OTSCS_REF_W-1:0] ref_trim_q;
    logic [`OTSCS_SLOW_W-1:0] slow_trim_q;
    otscs_src_t src_q;
    logic sel_lock_q;
    logic deep;
    logic wr_ref;
    logic wr_slow;
    logic wr_sel;
    logic sel_legal;

    assign rdy_raw = {slow_osc_ready, ref_osc_ready};

    // readiness comes from the analog side, so three stages and agreement filter
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    rdy_s1_q[gi] <= 1'b0;
                    rdy_s2_q[gi] <= 1'b0;
                    rdy_s3_q[gi] <= 1'b0;
                    rdy_f_q[gi] <= 1'b0;
                end
                else
                begin
                    rdy_s1_q[gi] <= rdy_raw[gi];
                    rdy_s2_q[gi] <= rdy_s1_q[gi];
                    rdy_s3_q[gi] <= rdy_s2_q[gi];
                    if (rdy_s2_q[gi] == rdy_s3_q[gi])
                    begin
                        rdy_f_q[gi] <= rdy_s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    assign ref_rdy = rdy_f_q[0];
    assign slow_rdy = rdy_f_q[1];
    assign deep = (pmu_mode == MODE_DEEP);

    // bus slave: a read right behind a write waits one cycle so it sees the new value
    assign addr_ok = hsel && hready && htrans[1];
    assign rd_req = addr_ok && !hwrite;
    assign wr_req = addr_ok && hwrite;
    assign hreadyout = !(hsel && htrans[1] && !hwrite && wr_pend_q);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0;
        end
        else
        begin
            wr_pend_q <= wr_req;
            if (wr_req)
            begin
                wr_addr_q <= haddr;
            end
        end
    end

    always_comb
    begin
        rd_val = 32'h0;
        if (reg_hit(haddr, `OTSCS_OFF_REF_TRIM))
        begin
            rd_val[`OTSCS_REF_W-1:0] = ref_trim_q;
        end
        else if (reg_hit(haddr, `OTSCS_OFF_SLOW_TRIM))
        begin
            rd_val[`OTSCS_SLOW_W-1:0] = slow_trim_q;
        end
        else if (reg_hit(haddr, `OTSCS_OFF_SLOW_SEL))
        begin
            rd_val[`OTSCS_SRC_W-1:0] = src_q;
            rd_val[`OTSCS_SEL_LOCK_BIT] = sel_lock_q;
        end
        else if (reg_hit(haddr, `OTSCS_OFF_STATUS))
        begin
            rd_val[`OTSCS_ST_REF_RDY] = ref_rdy;
            rd_val[`OTSCS_ST_SLOW_RDY] = slow_rdy;
            rd_val[`OTSCS_ST_REF_DONE] = (ref_st_q == INIT_DONE);
            rd_val[`OTSCS_ST_SLOW_DONE] = (slow_st_q == INIT_DONE);
            rd_val[`OTSCS_ST_LOCK] = sel_lock_q;
            rd_val[`OTSCS_ST_MODE_HI:`OTSCS_ST_MODE_LO] = pmu_mode;
        end
        else
        begin
            rd_val = 32'h0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hrdata_q <= 32'h0;
        end
        else if (rd_req)
        begin
            hrdata_q <= rd_val;
        end
    end

    // trims are refused until the default is in, so a cold boot always reads zero
    assign wr_ref = wr_pend_q && reg_hit(wr_addr_q, `OTSCS_OFF_REF_TRIM)
        && (ref_st_q == INIT_DONE) && !deep;
    assign wr_slow = wr_pend_q && reg_hit(wr_addr_q, `OTSCS_OFF_SLOW_TRIM)
        && (slow_st_q == INIT_DONE) && !deep;
    assign sel_legal = (hwdata[`OTSCS_SRC_W-1:0] == SRC_INTERNAL)
        || (hwdata[`OTSCS_SRC_W-1:0] == SRC_CRYSTAL)
        || (hwdata[`OTSCS_SRC_W-1:0] == SRC_EXTERNAL);
    assign wr_sel = wr_pend_q && reg_hit(wr_addr_q, `OTSCS_OFF_SLOW_SEL)
        && !sel_lock_q && !deep && sel_legal;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ref_st_q <= INIT_WAIT;
            ref_trim_q <= `OTSCS_REF_RST;
        end
        else
        begin
            case (ref_st_q)
                INIT_WAIT:
                begin
                    if (deep)
                    begin
                        ref_st_q <= INIT_HALT;
                    end
                    else if (ref_rdy)
                    begin
                        ref_st_q <= INIT_DONE;
                        ref_trim_q <= `OTSCS_REF_DEF;
                    end
                end
                INIT_DONE:
                begin
                    if (deep)
                    begin
                        ref_st_q <= INIT_HALT;
                        ref_trim_q <= `OTSCS_REF_RST;
                    end
                    else if (wr_ref)
                    begin
                        ref_trim_q <= hwdata[`OTSCS_REF_W-1:0];
                    end
                end
                INIT_HALT:
                begin
                    if (!deep)
                    begin
                        ref_st_q <= INIT_WAIT;
                    end
                end
                default:
                begin
                    ref_st_q <= INIT_WAIT;
                    ref_trim_q <= `OTSCS_REF_RST;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            slow_st_q <= INIT_WAIT;
            slow_trim_q <= `OTSCS_SLOW_RST;
        end
        else
        begin
            case (slow_st_q)
                INIT_WAIT:
                begin
                    if (deep)
                    begin
                        slow_st_q <= INIT_HALT;
                    end
                    else if (slow_rdy)
                    begin
                        slow_st_q <= INIT_DONE;
                        slow_trim_q <= `OTSCS_SLOW_DEF;
                    end
                end
                INIT_DONE:
                begin
                    if (deep)
                    begin
                        slow_st_q <= INIT_HALT;
                        slow_trim_q <= `OTSCS_SLOW_RST;
                    end
                    else if (wr_slow)
                    begin
                        slow_trim_q <= hwdata[`OTSCS_SLOW_W-1:0];
                    end
                end
                INIT_HALT:
                begin
                    if (!deep)
                    begin
                        slow_st_q <= INIT_WAIT;
                    end
                end
                default:
                begin
                    slow_st_q <= INIT_WAIT;
                    slow_trim_q <= `OTSCS_SLOW_RST;
                end
            endcase
        end
    end

    // deep sleep is a fresh start-up for the source choice as well
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            src_q <= SRC_INTERNAL;
            sel_lock_q <= 1'b0;
        end
        else if (deep)
        begin
            src_q <= SRC_INTERNAL;
            sel_lock_q <= 1'b0;
        end
        else if (wr_sel)
        begin
            src_q <= otscs_src_t'(hwdata[`OTSCS_SRC_W-1:0]);
            sel_lock_q <= 1'b1;
        end
    end

    // codes pass unchanged: the bank maps two's complement onto capacitance
    // one driver for the whole carrier; field order follows the package struct
    assign osc_trim = {ref_trim_q, slow_trim_q, src_q};
    assign ref_osc_en = (pmu_mode == MODE_RUN);
    assign slow_osc_en = !deep;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_REF_WRITE: assert property (wr_ref |=> osc_trim.ref_cap_trim == $past(hwdata[6:0]))
        else $error("reference trim write not applied");
    AST_SLOW_WRITE: assert property (wr_slow |=> osc_trim.slow_cap_trim == $past(hwdata[4:0]))
        else $error("sleep trim write not applied");
    AST_REF_ZERO_BOOT: assert property ((ref_st_q != INIT_DONE) |-> ref_trim_q == 7'h00)
        else $error("reference trim not zero before stable");
    AST_REF_DEFAULT: assert property ((ref_st_q == INIT_WAIT && ref_rdy && !deep)
        |=> ref_trim_q == 7'h1a && ref_st_q == INIT_DONE)
        else $error("reference default not loaded");
    AST_REF_RETAIN: assert property ((pmu_mode == MODE_SLEEP || pmu_mode == MODE_BACKUP)
        && ref_st_q == INIT_DONE && !wr_ref |=> $stable(ref_trim_q))
        else $error("reference trim lost in light sleep");
    AST_REF_STOP: assert property ((pmu_mode != MODE_RUN) |-> !ref_osc_en)
        else $error("reference oscillator running in low power");
    AST_DEEP_CLEAR: assert property (deep ##1 deep |-> ref_trim_q == 7'h00
        && slow_trim_q == 5'h00 && src_q == SRC_INTERNAL)
        else $error("trims not cleared in deep sleep");
    AST_SEL_ONCE: assert property (sel_lock_q && !deep |=> $stable(src_q))
        else $error("source changed after lock");
    AST_SEL_INTERNAL: assert property (!sel_lock_q |-> src_q == SRC_INTERNAL)
        else $error("source not internal before selection");
    AST_SLOW_DEFAULT: assert property ((slow_st_q == INIT_WAIT && slow_rdy && !deep)
        |=> slow_trim_q == 5'h18)
        else $error("sleep default not loaded");
    AST_SLOW_STOP: assert property (deep |-> !slow_osc_en)
        else $error("sleep clock running in deep sleep");
    AST_DEEP_WAKE: assert property ($fell(deep) |-> slow_trim_q == 5'h00
        ##1 slow_st_q == INIT_WAIT)
        else $error("sleep trim not restarted on wake");

    COV_REF_LOAD: cover property (ref_st_q == INIT_WAIT ##1 ref_st_q == INIT_DONE);
    COV_SEL_CRYSTAL: cover property (wr_sel ##1 src_q == SRC_CRYSTAL);
    COV_DEEP_CYCLE: cover property (deep ##1 !deep ##[1:20] slow_st_q == INIT_DONE);
    COV_SLEEP_RETAIN: cover property (pmu_mode == MODE_SLEEP ##1 pmu_mode == MODE_RUN);

endmodule // otscs_top

// >>> inc/otscs_cfg.svh
`ifndef OTSCS_CFG_SVH
`define OTSCS_CFG_SVH

// register byte offsets
`define OTSCS_OFF_REF_TRIM 8'h00
`define OTSCS_OFF_SLOW_TRIM 8'h04
`define OTSCS_OFF_SLOW_SEL 8'h08
`define OTSCS_OFF_STATUS 8'h0c

// field widths and synchronizer stage count
`define OTSCS_REF_W 7
`define OTSCS_SLOW_W 5
`define OTSCS_SRC_W 2
`define OTSCS_SYNC_N 3

// trim values at start-up and after oscillation is stable
`define OTSCS_REF_RST 7'h00
`define OTSCS_REF_DEF 7'h1a
`define OTSCS_SLOW_RST 5'h00
`define OTSCS_SLOW_DEF 5'h18

// field positions
`define OTSCS_SEL_LOCK_BIT 8
`define OTSCS_ST_REF_RDY 0
`define OTSCS_ST_SLOW_RDY 1
`define OTSCS_ST_REF_DONE 2
`define OTSCS_ST_SLOW_DONE 3
`define OTSCS_ST_LOCK 4
`define OTSCS_ST_MODE_LO 5
`define OTSCS_ST_MODE_HI 6

`endif

// >>> inc/otscs_pkg.sv
package otscs_pkg;
`include "otscs_cfg.svh"

typedef enum logic [1:0]
{
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_BACKUP = 2'b10,
    MODE_DEEP = 2'b11
} otscs_mode_t;

typedef enum logic [`OTSCS_SRC_W-1:0]
{
    SRC_INTERNAL = 2'b00,
    SRC_CRYSTAL = 2'b01,
    SRC_EXTERNAL = 2'b10
} otscs_src_t;

typedef enum logic [1:0]
{
    INIT_WAIT = 2'b00,
    INIT_DONE = 2'b01,
    INIT_HALT = 2'b10
} otscs_init_t;

typedef struct packed
{
    logic [`OTSCS_REF_W-1:0] ref_cap_trim;
    logic [`OTSCS_SLOW_W-1:0] slow_cap_trim;
    otscs_src_t slow_src;
} otscs_trim_t;

endpackage

// >>> verif/tb.sv
`timescale 1ns/100ps
`include "otscs_cfg.svh"
module tb;
    import otscs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    otscs_mode_t pmu_mode = MODE_RUN;
    logic ref_osc_ready = 1'b0;
    logic slow_osc_ready = 1'b0;
    logic ref_osc_en;
    logic slow_osc_en;
    otscs_trim_t osc_trim;
    logic rd_ph = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] v;
    logic [31:0] ref_edge[4] = '{32'h40, 32'h3f, 32'hffffff7f, 32'h0};
    logic [31:0] slow_edge[4] = '{32'h0f, 32'h10, 32'hffffffff, 32'h0};
    int failures = 0;
    int comparisons = 0;
    int i;

    otscs_top i_dut
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .pmu_mode(pmu_mode),
        .ref_osc_ready(ref_osc_ready),
        .slow_osc_ready(slow_osc_ready),
        .ref_osc_en(ref_osc_en),
        .slow_osc_en(slow_osc_en),
        .osc_trim(osc_trim)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hreadyout is combinational, so it is looked at mid-cycle and taken at the edge
    task automatic wait_ready();
        logic r;
        do
        begin
            @(negedge sys_clk);
            r = hreadyout;
            @(posedge sys_clk);
        end
        while (r !== 1'b1);
    endtask

    // for a read, d is the expected data handed to the monitor
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= ~w;
        if (!w)
            exp_q.push_back(d);
        wait_ready();
        rd_ph <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b0, a, d);
    endtask

    task automatic boot();
        ref_osc_ready <= 1'b1;
        slow_osc_ready <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 check("ref bank", 32'(osc_trim.ref_cap_trim), 32'(`OTSCS_REF_DEF));
        check("slow bank", 32'(osc_trim.slow_cap_trim), 32'(`OTSCS_SLOW_DEF));
        rd(`OTSCS_OFF_REF_TRIM, 32'(`OTSCS_REF_DEF));
        rd(`OTSCS_OFF_SLOW_TRIM, 32'(`OTSCS_SLOW_DEF));
        rd(`OTSCS_OFF_STATUS, 32'h0f);
    endtask

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        forever
        begin
            @(negedge sys_clk);
            if (rd_ph && hreadyout === 1'b1)
            begin
                check("hrdata", hrdata, exp_q.pop_front());
                check("hresp", 32'(hresp), 32'h0);
            end
        end
    end

    // whole run is a few hundred cycles
    initial
    begin
        #(40 * 4000);
        failures++;
        end_of_test();
    end

    initial
    begin
        v = $urandom(87);
        repeat (3) @(posedge sys_clk);
        check("ref in reset", 32'(osc_trim.ref_cap_trim), 32'h0);
        rst <= 1'b0;
        @(posedge sys_clk);
        // writes before the default load are dropped, so boot reads zero
        wr(`OTSCS_OFF_REF_TRIM, 32'h55);
        wr(`OTSCS_OFF_SLOW_TRIM, 32'h0a);
        rd(`OTSCS_OFF_REF_TRIM, 32'h0);
        rd(`OTSCS_OFF_SLOW_TRIM, 32'h0);
        rd(`OTSCS_OFF_SLOW_SEL, 32'h0);
        boot();
        for (i = 0; i < 12; i++)
        begin
            v = (i < 4) ? ref_edge[i] : $urandom;
            wr(`OTSCS_OFF_REF_TRIM, v);
            #1 check("ref bank", 32'(osc_trim.ref_cap_trim), v & 32'h7f);
            rd(`OTSCS_OFF_REF_TRIM, v & 32'h7f);
            v = (i < 4) ? slow_edge[i] : $urandom;
            wr(`OTSCS_OFF_SLOW_TRIM, v);
            #1 check("slow bank", 32'(osc_trim.slow_cap_trim), v & 32'h1f);
            rd(`OTSCS_OFF_SLOW_TRIM, v & 32'h1f);
        end
        wr(`OTSCS_OFF_REF_TRIM, 32'h2b);
        wr(`OTSCS_OFF_SLOW_TRIM, 32'h13);
        for (i = 0; i < 2; i++)
        begin
            pmu_mode <= (i == 0) ? MODE_SLEEP : MODE_BACKUP;
            repeat (2) @(posedge sys_clk);
            #1 check("ref en", 32'(ref_osc_en), 32'h0);
            check("slow en", 32'(slow_osc_en), 32'h1);
            check("ref kept", 32'(osc_trim.ref_cap_trim), 32'h2b);
        end
        pmu_mode <= MODE_RUN;
        @(posedge sys_clk);
        rd(`OTSCS_OFF_REF_TRIM, 32'h2b);
        rd(`OTSCS_OFF_SLOW_TRIM, 32'h13);
        // the reserved code must not use up the single choice
        wr(`OTSCS_OFF_SLOW_SEL, 32'h3);
        rd(`OTSCS_OFF_SLOW_SEL, 32'h0);
        // crystal chosen before any timed link traffic would start
        wr(`OTSCS_OFF_SLOW_SEL, 32'(SRC_CRYSTAL));
        #1 check("src", 32'(osc_trim.slow_src), 32'(SRC_CRYSTAL));
        wr(`OTSCS_OFF_SLOW_SEL, 32'(SRC_EXTERNAL));
        rd(`OTSCS_OFF_SLOW_SEL, 32'h101);
        rd(`OTSCS_OFF_STATUS, 32'h1f);
        wr(8'h10, 32'hffffffff);
        rd(8'h10, 32'h0);
        pmu_mode <= MODE_DEEP;
        ref_osc_ready <= 1'b0;
        slow_osc_ready <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 check("ref deep", 32'(osc_trim.ref_cap_trim), 32'h0);
        check("slow deep", 32'(osc_trim.slow_cap_trim), 32'h0);
        check("slow en", 32'(slow_osc_en), 32'h0);
        check("src deep", 32'(osc_trim.slow_src), 32'(SRC_INTERNAL));
        pmu_mode <= MODE_RUN;
        repeat (6) @(posedge sys_clk);
        wr(`OTSCS_OFF_REF_TRIM, 32'h11);
        rd(`OTSCS_OFF_REF_TRIM, 32'h0);
        rd(`OTSCS_OFF_SLOW_TRIM, 32'h0);
        boot();
        // deep wake counts as a fresh start-up for the source choice
        wr(`OTSCS_OFF_SLOW_SEL, 32'(SRC_EXTERNAL));
        rd(`OTSCS_OFF_SLOW_SEL, 32'h102);
        rd(`OTSCS_OFF_STATUS, 32'h1f);
        end_of_test();
    end
endmodule // tb
